// file: verilog/supervisor_map.svh
// timing constants and counter widths for the supply supervisor
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

`define CLK_PERIOD_PS 5000
`define RESET_HOLD_MS 140
`define RESET_HOLD_CYCLES ((`RESET_HOLD_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define WATCHDOG_TIMEOUT_MS 1600
`define WATCHDOG_TIMEOUT_CYCLES ((`WATCHDOG_TIMEOUT_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define MR_GLITCH_NS 100
`define MR_GLITCH_CYCLES (((`MR_GLITCH_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define UV_GLITCH_NS 8000
`define UV_GLITCH_CYCLES (((`UV_GLITCH_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define UV_DEEP_GLITCH_NS 1000
`define UV_DEEP_GLITCH_CYCLES (((`UV_DEEP_GLITCH_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FILTER_WIDTH 12
`define TIMER_WIDTH 32

`endif

// file: verilog/supervisor_pkg.sv
// types shared by the supply supervisor files
package supervisor_pkg;

  // reset causes after qualification
  typedef struct packed {
    logic undervolt;
    logic manual;
    logic watchdog;
  } cause_t;

  // synchronised pin levels
  typedef struct packed {
    logic undervolt;
    logic undervolt_deep;
    logic manual_n;
    logic strobe;
    logic strobe_valid;
  } pins_t;

  typedef enum logic [1:0] {
    OUT_ACTIVE_LOW,
    OUT_ACTIVE_HIGH,
    OUT_BOTH
  } out_mode_t;

endpackage : supervisor_pkg

// file: verilog/level_filter.sv
// synchroniser plus debounce filter for one asynchronous level
`timescale 1ns/1ps
`include "supervisor_map.svh"

module level_filter #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic [`FILTER_WIDTH-1:0] hold_cycles,
  output logic level
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic [`FILTER_WIDTH-1:0] count_reg;
  logic [`FILTER_WIDTH-1:0] count_next;
  logic level_reg;
  logic level_next;

  // three-stage synchroniser; only stages two and three are compared
  always_comb
  begin
    sync_next = {sync_reg[1:0], pin};
    count_next = count_reg;
    level_next = level_reg;
    if (sync_reg[2] != sync_reg[1] || sync_reg[2] == level_reg)
    begin
      count_next = '0;
    end
    else if (count_reg + 1'b1 >= hold_cycles)
    begin
      level_next = sync_reg[2];
      count_next = '0;
    end
    else
    begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_reg <= {3{IDLE_LEVEL}};
      count_reg <= '0;
      level_reg <= IDLE_LEVEL;
    end
    else if (ce)
    begin
      sync_reg <= sync_next;
      count_reg <= count_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule : level_filter

// file: verilog/supply_supervisor_watchdog.sv
// reset supervisor: undervoltage, manual reset and watchdog into one reset output
`timescale 1ns/1ps
`include "supervisor_map.svh"

// ----------------------------------------------------------------
// design notes
// ----------------------------------------------------------------
// every pin input is asynchronous and passes three flops before use
// both timers count clk cycles; their terminal counts come in as parameters
// so that a simulation can run short periods while silicon keeps the long ones
// a floating strobe arrives as a separate driven input, because the
// window comparator that senses it is analog and sits outside this block
// limitation: undervoltage depth is modelled in two steps, shallow and deep,
// not as a continuous duration against depth curve
// limitation: ce low freezes every timer, so frozen time is never counted
// trade-off: outputs are registered from the next state, in step with reset_active_reg, so that they leave
// flops directly and cannot glitch on a comb path into the processor
// ----------------------------------------------------------------

// How it works
// - reset asserts on undervoltage, manual reset low, or watchdog expiry
// - reset stays asserted for the hold period after the last cause
// - manual reset debounced; glitches of about 100 ns ignored
// - unconnected manual reset reads high, treated as inactive
// - every strobe edge clears the watchdog; 50 ns pulses detected
// - watchdog running through the timeout asserts reset plus hold period
// - undervoltage or manual reset also clears the watchdog
// - watchdog held cleared while reset asserted, counts after release
// - floating strobe disables the watchdog
// - undervoltage filtered; deeper dips tolerated for shorter time
// - active-low, active-high or complementary outputs by variant
module supply_supervisor_watchdog #(
  parameter logic [`TIMER_WIDTH-1:0] HOLD_CYCLES = `TIMER_WIDTH'(`RESET_HOLD_CYCLES),
  parameter logic [`TIMER_WIDTH-1:0] TIMEOUT_CYCLES = `TIMER_WIDTH'(`WATCHDOG_TIMEOUT_CYCLES),
  parameter supervisor_pkg::out_mode_t OUT_MODE = supervisor_pkg::OUT_BOTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic below_threshold,
  input wire logic below_threshold_deep,
  input wire logic manual_reset_n,
  input wire logic manual_reset_n_connected,
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_strobe_driven,
  output logic reset_out_n,
  output logic reset_out,
  output logic watchdog_expired
);

  // ----------------------------------------------------------------
  // pin qualification
  // ----------------------------------------------------------------

  supervisor_pkg::pins_t pins;
  supervisor_pkg::cause_t cause;
  logic mr_pin;
  logic uv_slow;
  logic uv_fast;

  assign mr_pin = manual_reset_n_connected ? manual_reset_n : 1'b1;

  level_filter #(.IDLE_LEVEL(1'b1)) mr_filter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(mr_pin),
    .hold_cycles(`FILTER_WIDTH'(`MR_GLITCH_CYCLES)),
    .level(pins.manual_n)
  );

  level_filter #(.IDLE_LEVEL(1'b0)) uv_filter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(below_threshold),
    .hold_cycles(`FILTER_WIDTH'(`UV_GLITCH_CYCLES)),
    .level(uv_slow)
  );

  level_filter #(.IDLE_LEVEL(1'b0)) uv_deep_filter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(below_threshold_deep),
    .hold_cycles(`FILTER_WIDTH'(`UV_DEEP_GLITCH_CYCLES)),
    .level(uv_fast)
  );

  assign pins.undervolt = uv_slow | uv_fast;
  assign pins.undervolt_deep = uv_fast;

  // ----------------------------------------------------------------
  // strobe synchroniser
  // ----------------------------------------------------------------

  // no debounce on the strobe: at 5 ns a 50 ns pulse spans ten samples
  logic [2:0] wdi_sync_reg;
  logic [2:0] wdi_sync_next;
  logic [2:0] drv_sync_reg;
  logic [2:0] drv_sync_next;
  logic wdi_level_reg;
  logic wdi_level_next;
  logic drv_level_reg;
  logic drv_level_next;
  logic strobe_edge;

  // a change counts once stages two and three agree
  always_comb
  begin
    wdi_sync_next = {wdi_sync_reg[1:0], watchdog_strobe_in};
    drv_sync_next = {drv_sync_reg[1:0], watchdog_strobe_driven};
    wdi_level_next = (wdi_sync_reg[2] == wdi_sync_reg[1]) ? wdi_sync_reg[2] : wdi_level_reg;
    drv_level_next = (drv_sync_reg[2] == drv_sync_reg[1]) ? drv_sync_reg[2] : drv_level_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wdi_sync_reg <= 3'h0;
      drv_sync_reg <= 3'h0;
      wdi_level_reg <= 1'b0;
      drv_level_reg <= 1'b0;
    end
    else if (ce)
    begin
      wdi_sync_reg <= wdi_sync_next;
      drv_sync_reg <= drv_sync_next;
      wdi_level_reg <= wdi_level_next;
      drv_level_reg <= drv_level_next;
    end
  end

  assign pins.strobe = wdi_level_reg;
  assign pins.strobe_valid = drv_level_reg;
  assign strobe_edge = (wdi_level_next != wdi_level_reg);

  // ----------------------------------------------------------------
  // shared terminal-count decode
  // ----------------------------------------------------------------

  // used by both the watchdog and the hold counter
  function automatic logic count_done(
    input logic [`TIMER_WIDTH-1:0] count,
    input logic [`TIMER_WIDTH-1:0] limit
  );
    // look one ahead so the terminal count itself is the last cycle
    return (count + 1'b1) >= limit;
  endfunction : count_done

  // ----------------------------------------------------------------
  // watchdog timer
  // ----------------------------------------------------------------

  // the timer only runs while reset is released and the strobe is driven;
  // any pin cause wins over the strobe so a reset never leaves a stale count
  logic [`TIMER_WIDTH-1:0] wd_count_reg;
  logic [`TIMER_WIDTH-1:0] wd_count_next;
  logic wd_fire;
  logic reset_active_reg;

  // counter clears on any strobe edge, any reset, or while disabled
  always_comb
  begin
    wd_fire = 1'b0;
    wd_count_next = wd_count_reg;
    if (reset_active_reg || cause.undervolt || cause.manual)
    begin
      wd_count_next = '0;
    end
    else if (!pins.strobe_valid)
    begin
      wd_count_next = '0;
    end
    else if (strobe_edge)
    begin
      wd_count_next = '0;
    end
    else if (count_done(wd_count_reg, TIMEOUT_CYCLES))
    begin
      wd_fire = 1'b1;
      wd_count_next = '0;
    end
    else
    begin
      wd_count_next = wd_count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wd_count_reg <= '0;
    end
    else if (ce)
    begin
      wd_count_reg <= wd_count_next;
    end
  end

  assign cause.undervolt = pins.undervolt;
  assign cause.manual = ~pins.manual_n;
  assign cause.watchdog = wd_fire;

  // ----------------------------------------------------------------
  // reset hold stretcher
  // ----------------------------------------------------------------

  logic [`TIMER_WIDTH-1:0] hold_count_reg;
  logic [`TIMER_WIDTH-1:0] hold_count_next;
  logic reset_active_next;
  logic wd_flag_reg;
  logic wd_flag_next;
  logic reset_out_n_reg;
  logic reset_out_reg;

  // any cause reloads the hold count; release after it runs out
  // the watchdog flag marks only the reset that the timer itself started,
  // so a later pin cause during the hold period clears it again
  always_comb
  begin
    hold_count_next = hold_count_reg;
    reset_active_next = reset_active_reg;
    wd_flag_next = wd_flag_reg;
    if (cause.undervolt || cause.manual || cause.watchdog)
    begin
      reset_active_next = 1'b1;
      hold_count_next = '0;
      if (cause.watchdog)
      begin
        wd_flag_next = 1'b1;
      end
      else
      begin
        wd_flag_next = 1'b0;
      end
    end
    else if (reset_active_reg)
    begin
      if (count_done(hold_count_reg, HOLD_CYCLES))
      begin
        reset_active_next = 1'b0;
        wd_flag_next = 1'b0;
        hold_count_next = '0;
      end
      else
      begin
        hold_count_next = hold_count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // power-on: reset asserted and a full hold period follows
      hold_count_reg <= '0;
      reset_active_reg <= 1'b1;
      wd_flag_reg <= 1'b0;
      reset_out_n_reg <= 1'b0;
      reset_out_reg <= 1'b1;
    end
    else if (ce)
    begin
      hold_count_reg <= hold_count_next;
      reset_active_reg <= reset_active_next;
      wd_flag_reg <= wd_flag_next;
      reset_out_n_reg <= (OUT_MODE == supervisor_pkg::OUT_ACTIVE_HIGH) ? 1'b0 : ~reset_active_next;
      reset_out_reg <= (OUT_MODE == supervisor_pkg::OUT_ACTIVE_LOW) ? 1'b0 : reset_active_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // all three come straight from flops
  assign reset_out_n = reset_out_n_reg;
  assign reset_out = reset_out_reg;
  assign watchdog_expired = wd_flag_reg;

endmodule : supply_supervisor_watchdog

// file: test/supervisor_cpu_model.sv
// processor model: services the watchdog strobe, stalls, or floats the pin
`timescale 1ns/1ps
module supervisor_cpu_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic float_pin,
  input wire logic [7:0] period,
  output logic strobe,
  output logic driven
);
  logic [7:0] cnt = 8'h00;
  logic lvl = 1'b0;
  logic tog = 1'b0;
  // brief high pulse each period, stuck low when stalled
  always @(posedge clk)
  begin
    cnt <= (cnt >= period) ? 8'h00 : cnt + 8'h01;
    lvl <= !stall && (cnt < 8'h0C);
    tog <= !tog;
  end
  // a released pin shows a moving pattern so no stale level can pass
  assign strobe = float_pin ? tog : lvl;
  assign driven = !float_pin;
endmodule : supervisor_cpu_model

// file: test/supply_supervisor_watchdog_asserts.sv
// port checks for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_watchdog_asserts #(
  parameter int HOLD_CYCLES = 50,
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic below_threshold,
  input wire logic below_threshold_deep,
  input wire logic manual_reset_n,
  input wire logic manual_reset_n_connected,
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_strobe_driven,
  input wire logic reset_out_n,
  input wire logic reset_out,
  input wire logic watchdog_expired
);
  int mr_cnt;
  int uv_cnt;
  int dp_cnt;
  int wd_age;
  int calm;
  logic stb_d;
  // cause lengths, cycles since a strobe edge, cycles since the last pin cause
  always_ff @(posedge clk)
  begin
    stb_d <= watchdog_strobe_in;
    mr_cnt <= (manual_reset_n || !manual_reset_n_connected) ? 0 : mr_cnt + 1;
    uv_cnt <= below_threshold ? uv_cnt + 1 : 0;
    dp_cnt <= below_threshold_deep ? dp_cnt + 1 : 0;
    wd_age <= (rst || reset_out || !watchdog_strobe_driven || stb_d != watchdog_strobe_in) ? 0 : wd_age + 1;
    calm <= (rst || mr_cnt != 0 || below_threshold) ? 0 : calm + 1;
  end
  // margins cover the synchroniser and output register latency
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  property p_both; reset_out_n != reset_out; endproperty
  a_both: assert property (p_both) else $error("reset outputs not complementary");
  property p_boot; $fell(rst) |-> reset_out [*8]; endproperty
  a_boot: assert property (p_boot) else $error("reset dropped after init");
  property p_mr; mr_cnt == 40 |-> reset_out; endproperty
  a_mr: assert property (p_mr) else $error("manual reset held, no reset");
  property p_uv; uv_cnt == 1700 |-> reset_out; endproperty
  a_uv: assert property (p_uv) else $error("long dip, no reset");
  property p_deep; dp_cnt == 260 |-> reset_out; endproperty
  a_deep: assert property (p_deep) else $error("deep dip, no reset");
  property p_wd_late; watchdog_strobe_driven && !reset_out |-> wd_age < TIMEOUT_CYCLES + 30; endproperty
  a_wd_late: assert property (p_wd_late) else $error("watchdog expiry missed");
  property p_wd_early; $rose(watchdog_expired) |-> wd_age >= TIMEOUT_CYCLES - 4; endproperty
  a_wd_early: assert property (p_wd_early) else $error("watchdog expired early");
  property p_release; $fell(reset_out) |-> calm >= HOLD_CYCLES - 2; endproperty
  a_release: assert property (p_release) else $error("reset released before hold");
  c_wd: cover property ($rose(watchdog_expired));
  c_mr: cover property (mr_cnt == 40);
  c_rel: cover property ($fell(reset_out));
endmodule : supply_supervisor_watchdog_asserts

// file: test/supply_supervisor_watchdog_tb.sv
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb;
  localparam int HOLD = 50;
  localparam int TMO = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic uv = 1'b0;
  logic deep = 1'b0;
  logic mr_n = 1'b1;
  logic mr_con = 1'b1;
  logic stall = 1'b0;
  logic flt = 1'b0;
  logic [7:0] period = 8'h40;
  logic strobe, driven, rout_n, rout, wd_exp;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] seed = 32'h00000039;
  supply_supervisor_watchdog #(.HOLD_CYCLES(32'(HOLD)), .TIMEOUT_CYCLES(32'(TMO))) uut (
    .clk(clk), .rst(rst), .ce(1'b1), .below_threshold(uv), .below_threshold_deep(deep),
    .manual_reset_n(mr_n), .manual_reset_n_connected(mr_con), .watchdog_strobe_in(strobe),
    .watchdog_strobe_driven(driven), .reset_out_n(rout_n), .reset_out(rout), .watchdog_expired(wd_exp));
  supervisor_cpu_model cpu (.clk(clk), .stall(stall), .float_pin(flt), .period(period), .strobe(strobe),
    .driven(driven));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic exp_rst(input int len, input int span);
    return len > span;
  endfunction : exp_rst
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rst(input logic lvl, input int lim);
    for (int i = 0; i < lim && rout !== lvl; i++)
      cyc(1);
  endtask : wait_rst
  // kind 0 manual, 1 shallow dip, 2 deep dip, 3 manual on an open pin
  task automatic pulse(input int kind, input int len);
    int span;
    span = kind == 0 ? 20 : kind == 1 ? 1600 : kind == 2 ? 200 : 99999;
    mr_con = kind != 3;
    mr_n = kind == 1 || kind == 2;
    uv = kind == 1 || kind == 2;
    deep = kind == 2;
    cyc(len);
    mr_n = 1'b1;
    uv = 1'b0;
    deep = 1'b0;
    mr_con = 1'b1;
    cyc(20);
    chk(rout, exp_rst(len, span));
    chk(rout_n, !exp_rst(len, span));
    wait_rst(1'b0, 3000);
    chk(rout, 1'b0);
  endtask : pulse
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    cyc(16);
    rst = 1'b0;
    chk(rout, 1'b1);
    wait_rst(1'b0, HOLD + 50);
    chk(rout, 1'b0);
    // random service intervals must never let the watchdog fire
    repeat (8)
    begin
      period = 8'(40 + xs() % 110);
      cyc(300);
      chk(rout, 1'b0);
    end
    repeat (4)
      pulse(0, 1 + xs() % 15);
    repeat (2)
      pulse(0, 30 + xs() % 30);
    pulse(3, 60);
    pulse(1, 1000);
    pulse(1, 1800);
    pulse(2, 150);
    pulse(2, 300);
    pulse(0, 210); // held past 1 us
    // stalled strobe, then a manual reset that must restart the timer
    stall = 1'b1;
    cyc(150);
    pulse(0, 40);
    cyc(TMO - 20);
    chk(rout, 1'b0);
    wait_rst(1'b1, 60);
    chk(wd_exp, 1'b1);
    stall = 1'b0;
    wait_rst(1'b0, HOLD + 100);
    chk(rout, 1'b0);
    flt = 1'b1;
    cyc(3 * TMO);
    chk(rout, 1'b0);
    flt = 1'b0;
    cyc(50);
    chk(rout, 1'b0);
    summarize();
  end
  // hang guard well beyond the expected run
  initial
  begin
    cyc(40000);
    bad_count++;
    summarize();
  end
endmodule : supply_supervisor_watchdog_tb
bind supply_supervisor_watchdog supply_supervisor_watchdog_asserts #(.HOLD_CYCLES(HOLD_CYCLES),
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (.clk(clk), .rst(rst), .ce(ce), .below_threshold(below_threshold),
  .below_threshold_deep(below_threshold_deep), .manual_reset_n(manual_reset_n),
  .manual_reset_n_connected(manual_reset_n_connected), .watchdog_strobe_in(watchdog_strobe_in),
  .watchdog_strobe_driven(watchdog_strobe_driven), .reset_out_n(reset_out_n), .reset_out(reset_out),
  .watchdog_expired(watchdog_expired));
